// ===== rtl/pdm_power_ctrl.sv
// Top: power-down and module-stop registers with standby outputs
`timescale 1ns/1ns
`default_nettype none
module pdm_power_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hw_standby,
  input wire logic [19:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_req,
  input wire logic wake_irq,
  input wire logic [23:0] bus_addr_in,
  input wire logic [11:0] bus_ctl_in,
  output logic [23:0] bus_addr_out,
  output logic bus_addr_oe,
  output logic [11:0] bus_ctl_out,
  output logic bus_ctl_oe,
  output logic clock_out_en,
  output logic cpu_halt,
  output logic clock_release,
  output logic stop_serial_0,
  output logic stop_serial_1,
  output logic stop_serial_2,
  output logic stop_dma_unit,
  output logic stop_dram_interface,
  output logic stop_wide_timer,
  output logic stop_byte_timer_01,
  output logic stop_byte_timer_23,
  output logic stop_adc,
  output logic [7:0] periph_init
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] power_down_control;
  logic [7:0] module_stop_control_high;
  logic [7:0] module_stop_control_low;
  logic [7:0] stop_vec;
  logic [7:0] stop_prev;
  logic [23:0] addr_hold;
  logic hws_q1;
  logic hws;
  logic in_standby;
  logic wr_pdc;
  logic wr_msh;
  logic wr_msl;
  pdm_regs_if cfg ();

  // Hardware standby pin crosses in through two flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hws_q1 <= 1'b0;
      hws <= 1'b0;
    end
    else
    begin
      hws_q1 <= hw_standby;
      hws <= hws_q1;
    end
  end

  assign wr_pdc = reg_wr && (reg_addr == pdm_pkg::OFS_PDC);
  assign wr_msh = reg_wr && (reg_addr == pdm_pkg::OFS_MSH);
  assign wr_msl = reg_wr && (reg_addr == pdm_pkg::OFS_MSL);

  ////////////////////////////////////////////////////////////////////////////
  // Control register; deep bit changes only by a write or hardware standby, never by wake-up
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      power_down_control <= pdm_pkg::RST_PDC;
    else if (hws)
      power_down_control <= pdm_pkg::RST_PDC;
    else if (wr_pdc)
      power_down_control <= reg_wdata;
  end

  // High stop register; reserved bits forced to one on every write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      module_stop_control_high <= pdm_pkg::RST_MSH;
    else if (hws)
      module_stop_control_high <= pdm_pkg::RST_MSH;
    else if (wr_msh)
      module_stop_control_high <= reg_wdata | pdm_pkg::MSH_RSV_MASK;
  end

  // Low stop register; software standby does not touch it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      module_stop_control_low <= pdm_pkg::RST_MSL;
    else if (hws)
      module_stop_control_low <= pdm_pkg::RST_MSL;
    else if (wr_msl)
      module_stop_control_low <= reg_wdata;
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        pdm_pkg::OFS_PDC: reg_rdata <= power_down_control;
        pdm_pkg::OFS_MSH:
          reg_rdata <= module_stop_control_high | pdm_pkg::MSH_RSV_MASK;
        pdm_pkg::OFS_MSL: reg_rdata <= module_stop_control_low;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cfg.deep = power_down_control[pdm_pkg::BIT_DEEP];
  assign cfg.sts = power_down_control[pdm_pkg::BIT_STS_LO +: 3];
  assign cfg.keep = power_down_control[pdm_pkg::BIT_KEEP];

  pdm_settle_seq u_seq (
    .clk(clk),
    .reset_n(reset_n),
    .sleep_req(sleep_req),
    .wake_irq(wake_irq),
    .cfg(cfg.seq),
    .cpu_halt(cpu_halt),
    .in_standby(in_standby),
    .clock_release(clock_release)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Last address latched while running so standby can keep driving it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      addr_hold <= 24'h000000;
    else if (!in_standby)
      addr_hold <= bus_addr_in;
  end

  // Bus pins in standby: float, or hold address with controls high
  always_comb
  begin
    bus_addr_out = bus_addr_in;
    bus_ctl_out = bus_ctl_in;
    bus_addr_oe = 1'b1;
    bus_ctl_oe = 1'b1;
    if (in_standby)
    begin
      bus_addr_out = addr_hold;
      bus_ctl_out = 12'hFFF;
      bus_addr_oe = cfg.keep;
      bus_ctl_oe = cfg.keep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock pin; enable follows only the clock-out disable bit, standby does not gate it
  assign clock_out_en = !module_stop_control_high[pdm_pkg::BIT_CKOFF];

  assign stop_serial_2 = module_stop_control_high[2];
  assign stop_serial_1 = module_stop_control_high[1];
  assign stop_serial_0 = module_stop_control_high[0];
  assign stop_dma_unit = module_stop_control_low[7];
  assign stop_dram_interface = module_stop_control_low[5];
  assign stop_wide_timer = module_stop_control_low[4];
  assign stop_byte_timer_01 = module_stop_control_low[3];
  assign stop_byte_timer_23 = module_stop_control_low[2];
  assign stop_adc = module_stop_control_low[0];

  // Bit order of stop_vec matches periph_init lanes
  assign stop_vec = {stop_dma_unit, stop_dram_interface, stop_wide_timer,
                     stop_byte_timer_01, stop_byte_timer_23, stop_adc,
                     stop_serial_1, stop_serial_0};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      stop_prev <= 8'h00;
    else
      stop_prev <= stop_vec;
  end

  // One-cycle init pulse per peripheral except serial 2 when its stop bit rises
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_init
      assign periph_init[gi] = stop_vec[gi] && !stop_prev[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  chk_msh_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    wr_msh |=> (module_stop_control_high[6:3] == 4'hF))
    else $error("high reserved bits not one");
  chk_msh_read: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == pdm_pkg::OFS_MSH |=> reg_rdata[6:3] == 4'hF)
    else $error("high reserved bits read wrong");
  chk_msl_store: assert property (@(posedge clk) disable iff (!reset_n)
    wr_msl && !hws |=> module_stop_control_low == $past(reg_wdata))
    else $error("low register did not store");
  chk_deep_kept: assert property (@(posedge clk) disable iff (!reset_n)
    !wr_pdc && !hws |=> $stable(power_down_control[7]))
    else $error("deep bit changed without write");
  chk_sleep_mode: assert property (@(posedge clk) disable iff (!reset_n)
    !cpu_halt && sleep_req && !cfg.deep |=> cpu_halt && !in_standby)
    else $error("sleep mode not entered");
  chk_stby_mode: assert property (@(posedge clk) disable iff (!reset_n)
    !cpu_halt && sleep_req && cfg.deep |=> in_standby)
    else $error("standby not entered");
  chk_bus_float: assert property (@(posedge clk) disable iff (!reset_n)
    in_standby && !cfg.keep |-> !bus_addr_oe && !bus_ctl_oe)
    else $error("bus not floated");
  chk_bus_keep: assert property (@(posedge clk) disable iff (!reset_n)
    in_standby && cfg.keep |-> bus_addr_oe && bus_ctl_out == 12'hFFF)
    else $error("bus controls not held high");
  chk_hws_reset: assert property (@(posedge clk) disable iff (!reset_n)
    hws |=> module_stop_control_high == 8'h78 &&
      module_stop_control_low == 8'h00)
    else $error("hardware standby reset missed");
  chk_stop_init: assert property (@(posedge clk) disable iff (!reset_n)
    wr_msl && reg_wdata[0] && !stop_adc && !hws |=> periph_init[2])
    else $error("init pulse missing");
  chk_clk_out: assert property (@(posedge clk) disable iff (!reset_n)
    wr_msh && !hws |=> clock_out_en == !$past(reg_wdata[7]))
    else $error("clock out enable wrong");

  cov_sleep: cover property (@(posedge clk) disable iff (!reset_n)
    !cpu_halt && sleep_req && !cfg.deep);
  cov_standby_wake: cover property (@(posedge clk) disable iff (!reset_n)
    in_standby ##1 !in_standby);
  cov_keep_bus: cover property (@(posedge clk) disable iff (!reset_n)
    in_standby && cfg.keep);
  cov_hws: cover property (@(posedge clk) disable iff (!reset_n) hws);
endmodule // pdm_power_ctrl
`default_nettype wire

// ===== rtl/pdm_settle_seq.sv
// Sequencer: sleep, software standby and settle wait on wake-up
`timescale 1ns/1ns
`default_nettype none
module pdm_settle_seq (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sleep_req,
  input wire logic wake_irq,
  pdm_regs_if.seq cfg,
  output logic cpu_halt,
  output logic in_standby,
  output logic clock_release
);
  pdm_pkg::pdm_state_t state;
  logic [pdm_pkg::CNT_W-1:0] cnt;

  // Mode walk; the wait code is sampled at wake so later writes cannot stretch it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= pdm_pkg::PDM_RUN;
      cnt <= '0;
    end
    else
    begin
      unique case (state)
        pdm_pkg::PDM_RUN:
        begin
          if (sleep_req)
            state <= cfg.deep ? pdm_pkg::PDM_STBY : pdm_pkg::PDM_SLEEP;
        end
        pdm_pkg::PDM_SLEEP:
        begin
          if (wake_irq)
            state <= pdm_pkg::PDM_RUN;
        end
        pdm_pkg::PDM_STBY:
        begin
          if (wake_irq)
          begin
            state <= pdm_pkg::PDM_SETTLE;
            cnt <= pdm_pkg::pdm_wait(cfg.sts);
          end
        end
        pdm_pkg::PDM_SETTLE:
        begin
          if (cnt == '0)
            state <= pdm_pkg::PDM_RUN;
          else
            cnt <= cnt - 1'b1;
        end
        default: state <= pdm_pkg::PDM_RUN;
      endcase
    end
  end

  // Clocks held off through standby and the whole settle wait
  assign cpu_halt = (state != pdm_pkg::PDM_RUN);
  assign in_standby = (state == pdm_pkg::PDM_STBY) ||
                      (state == pdm_pkg::PDM_SETTLE);
  assign clock_release = !in_standby;

  // Age and length of the running settle wait; a counter bounds the wait
  // because the longest codes are far beyond any delay range
  logic [pdm_pkg::CNT_W-1:0] settle_age;
  logic [pdm_pkg::CNT_W-1:0] settle_len;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settle_age <= '0;
      settle_len <= '0;
    end
    else
    begin
      if (state == pdm_pkg::PDM_STBY && wake_irq)
        settle_len <= pdm_pkg::pdm_wait(cfg.sts);
      if (state == pdm_pkg::PDM_SETTLE)
        settle_age <= settle_age + 1'b1;
      else
        settle_age <= '0;
    end
  end

  chk_settle_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (state == pdm_pkg::PDM_STBY && wake_irq && cfg.sts == 3'h6)
      |=> !clock_release [*8] ##1 !clock_release [*8])
    else $error("settle wait ended too early");
  chk_settle_end: assert property (@(posedge clk) disable iff (!reset_n)
    (state == pdm_pkg::PDM_SETTLE) |-> (settle_age <= settle_len))
    else $error("settle wait did not end");
endmodule // pdm_settle_seq
`default_nettype wire

// ===== shared/pdm_pkg.sv
// Package: register map, fields, resets and wait codes for the power-down block
// Operation
// - Standby select picks sleep or deep standby
// - Standby select survives interrupt wake-up
// - Settle code maps to documented state counts
// - Settle wait precedes resume after interrupt
// - Bus keep zero floats bus in standby
// - Bus keep one holds address, controls high
// - Clock-out disable bit gates clock pin
// - High reserved bits ignore writes, read one
// - High bits stop serial channels
// - High register resets to 78
// - Low register resets to 00, kept
// - Low bits stop dma, dram, wide timer
// - Low bits stop byte timers and adc
// - Low reserved bits are plain storage
// - Offsets are low 20 address bits
// - Stop bit resets its peripheral; serial 2 gets no init pulse
// - Sleep halts processor, others run
// - Interrupt restarts oscillator, waits, releases
package pdm_pkg;
  localparam int ADDR_W = 20;
  localparam logic [19:0] OFS_PDC = 20'hEE012;
  localparam logic [19:0] OFS_MSH = 20'hEE01C;
  localparam logic [19:0] OFS_MSL = 20'hEE01D;
  localparam logic [7:0] RST_PDC = 8'h09;
  localparam logic [7:0] RST_MSH = 8'h78;
  localparam logic [7:0] RST_MSL = 8'h00;
  localparam logic [7:0] MSH_RSV_MASK = 8'h78;
  localparam int BIT_DEEP = 7;
  localparam int BIT_STS_LO = 4;
  localparam int BIT_KEEP = 1;
  localparam int BIT_CKOFF = 7;
  localparam int CNT_W = 18;
  localparam logic [2:0] STS_ILLEGAL = 3'h7;
  typedef enum logic [3:0] {
    PDM_RUN = 4'h1,
    PDM_SLEEP = 4'h2,
    PDM_STBY = 4'h4,
    PDM_SETTLE = 4'h8
  } pdm_state_t;
  // Wait in states for each settle code, minus one for the down-counter
  function automatic logic [CNT_W-1:0] pdm_wait(input logic [2:0] code);
    logic [CNT_W-1:0] w;
    w = 18'h01FFF;
    unique case (code)
      3'h0: w = 18'h01FFF;
      3'h1: w = 18'h03FFF;
      3'h2: w = 18'h07FFF;
      3'h3: w = 18'h0FFFF;
      3'h4: w = 18'h1FFFF;
      3'h5: w = 18'h3FFFF;
      3'h6: w = 18'h003FF;
      default: w = 18'h3FFFF; // illegal code, take the longest
    endcase
    return w;
  endfunction
endpackage

// ===== shared/pdm_regs_if.sv
// Interface: register values passed from register file to the sequencer
`timescale 1ns/1ns
`default_nettype none
interface pdm_regs_if;
  logic deep;
  logic [2:0] sts;
  logic keep;
  modport regs (output deep, output sts, output keep);
  modport seq (input deep, input sts, input keep);
endinterface : pdm_regs_if
`default_nettype wire

// ===== tb/tb.sv
// Testbench: register access, module stop and standby sequencing
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, reset_n, hw_standby, reg_wr, reg_rd, sleep_req, wake_irq;
  logic [19:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, periph_init;
  logic [23:0] bus_addr_in, bus_addr_out;
  logic [11:0] bus_ctl_in, bus_ctl_out;
  logic bus_addr_oe, bus_ctl_oe, clock_out_en, cpu_halt, clock_release;
  logic stop_serial_0, stop_serial_1, stop_serial_2, stop_dma_unit;
  logic stop_dram_interface, stop_wide_timer, stop_byte_timer_01;
  logic stop_byte_timer_23, stop_adc;
  int n_fail, tests_run, cyc, cnt;
  logic [7:0] rv;

  pdm_power_ctrl uut (.clk, .reset_n, .hw_standby, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .sleep_req, .wake_irq, .bus_addr_in,
    .bus_ctl_in, .bus_addr_out, .bus_addr_oe, .bus_ctl_out, .bus_ctl_oe,
    .clock_out_en, .cpu_halt, .clock_release, .stop_serial_0,
    .stop_serial_1, .stop_serial_2, .stop_dma_unit, .stop_dram_interface,
    .stop_wide_timer, .stop_byte_timer_01, .stop_byte_timer_23, .stop_adc,
    .periph_init);

  ////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so a stuck wait cannot hang the run
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] seen,
                     input logic [23:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data is sampled in the one cycle after the strobe
  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic pulse(input bit wake);
    @(posedge clk);
    if (wake) wake_irq <= 1'b1;
    else sleep_req <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    sleep_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {n_fail, tests_run, cyc} = '0;
    {reset_n, hw_standby, reg_wr, reg_rd, sleep_req, wake_irq} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    bus_addr_in = 24'h5A3C96;
    bus_ctl_in = 12'h000;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values and an unmapped place
    rd(pdm_pkg::OFS_PDC, rv); chk("pdc", rv, 8'h09);
    rd(pdm_pkg::OFS_MSH, rv); chk("msh", rv, 8'h78);
    rd(pdm_pkg::OFS_MSL, rv); chk("msl", rv, 8'h00);
    rd(20'hEE013, rv); chk("unmapped", rv, 8'h00);
    chk("clk_out", clock_out_en, 1'b1);
    // High register: reserved bits read one, stops and clock gate
    wr(pdm_pkg::OFS_MSH, 8'h87);
    chk("init_h", periph_init, 8'h03);
    chk("ser", {stop_serial_2, stop_serial_1, stop_serial_0}, 3'h7);
    chk("clk_off", clock_out_en, 1'b0);
    rd(pdm_pkg::OFS_MSH, rv); chk("msh_ff", rv, 8'hFF);
    wr(pdm_pkg::OFS_MSH, 8'h00);
    rd(pdm_pkg::OFS_MSH, rv); chk("msh_78", rv, 8'h78);
    chk("ser0", {stop_serial_2, stop_serial_1, stop_serial_0}, 3'h0);
    // Low register: one stop, then all bits incl. plain storage
    wr(pdm_pkg::OFS_MSL, 8'h01);
    chk("init_adc", periph_init, 8'h04);
    chk("adc", stop_adc, 1'b1);
    wr(pdm_pkg::OFS_MSL, 8'hFF);
    chk("init_l", periph_init, 8'hF8);
    chk("stops_l", {stop_dma_unit, stop_dram_interface, stop_wide_timer,
      stop_byte_timer_01, stop_byte_timer_23}, 5'h1F);
    wr(pdm_pkg::OFS_MSL, 8'h42);
    rd(pdm_pkg::OFS_MSL, rv); chk("msl_rsv", rv, 8'h42);
    // Sleep: processor halts, clocks keep running
    wr(pdm_pkg::OFS_PDC, 8'h60);
    pulse(1'b0);
    chk("sleep_halt", {cpu_halt, clock_release}, 2'h3);
    pulse(1'b1);
    chk("sleep_exit", cpu_halt, 1'b0);
    // Standby with bus kept, then timed settle of 1024 states
    wr(pdm_pkg::OFS_PDC, 8'hE2);
    pulse(1'b0);
    chk("stby", {cpu_halt, clock_release}, 2'h2);
    chk("keep_oe", {bus_addr_oe, bus_ctl_oe}, 2'h3);
    chk("keep_ctl", bus_ctl_out, 12'hFFF);
    chk("keep_addr", bus_addr_out, 24'h5A3C96);
    @(posedge clk);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    #1;
    cnt = 0;
    while (clock_release !== 1'b1 && cnt < 3000)
    begin
      @(posedge clk);
      #1;
      cnt = cnt + 1;
    end
    chk("settle", cnt, 24'h000400);
    rd(pdm_pkg::OFS_PDC, rv); chk("deep_kept", rv, 8'hE2);
    rd(pdm_pkg::OFS_MSL, rv); chk("msl_kept", rv, 8'h42);
    // Standby without keep floats the bus
    // 16384 states at 8 ns clear the 100 us external-clock minimum
    wr(pdm_pkg::OFS_PDC, 8'h90);
    pulse(1'b0);
    chk("float_oe", {bus_addr_oe, bus_ctl_oe}, 2'h0);
    pulse(1'b1);
    repeat (16300) @(posedge clk);
    #1;
    chk("still_wait", clock_release, 1'b0);
    repeat (200) @(posedge clk);
    #1;
    chk("awake", {cpu_halt, clock_release}, 2'h1);
    // Hardware standby reloads every register
    wr(pdm_pkg::OFS_MSH, 8'h05);
    @(posedge clk);
    hw_standby <= 1'b1;
    repeat (6) @(posedge clk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge clk);
    rd(pdm_pkg::OFS_PDC, rv); chk("hw_pdc", rv, 8'h09);
    rd(pdm_pkg::OFS_MSH, rv); chk("hw_msh", rv, 8'h78);
    rd(pdm_pkg::OFS_MSL, rv); chk("hw_msl", rv, 8'h00);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
